// ==== acs_pkg.sv ====
// Constants, types and helper functions for the audio clock source block.
// Assumes a 100 MHz pclk; the link timeout and the sample frame periods in cycles derive from that rate.
package acs_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'h00C;
  localparam logic [11:0] OFF_IRQ_EN   = 12'h010;

  // Control field positions and reset value
  localparam int          CTRL_SRC_BIT  = 0;
  localparam int          CTRL_RATE_LSB = 4;
  localparam int          CTRL_FMT_BIT  = 8;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0020;

  // Interrupt bit positions
  localparam int IRQ_LOCK_UP   = 0;
  localparam int IRQ_LOCK_DOWN = 1;
  localparam int IRQ_SYNC_CHG  = 2;
  localparam int IRQ_SRC_CHG   = 3;
  localparam int IRQ_RATE_CHG  = 4;
  localparam int IRQ_W         = 5;

  // Channel enable masks per speed band and format
  localparam logic [7:0] CH_ALL  = 8'hFF;
  localparam logic [7:0] CH_SMUX = 8'h0F;
  localparam logic [7:0] CH_QUAD = 8'h03;

  // Link activity: link clock period is far below this
  localparam int unsigned LINK_TO_NS  = 1000;
  localparam int unsigned LINK_TO_CYC = (LINK_TO_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned FRAME_TO_CYC = 5000;
  localparam int unsigned PER_W        = 13;
  localparam int unsigned SYNC_TOL     = 4;

  // Sample frame periods in pclk cycles
  localparam int unsigned P_32K  = CLK_HZ / 32000;
  localparam int unsigned P_44K  = CLK_HZ / 44100;
  localparam int unsigned P_48K  = CLK_HZ / 48000;
  localparam int unsigned P_64K  = CLK_HZ / 64000;
  localparam int unsigned P_88K  = CLK_HZ / 88200;
  localparam int unsigned P_96K  = CLK_HZ / 96000;
  localparam int unsigned P_128K = CLK_HZ / 128000;
  localparam int unsigned P_176K = CLK_HZ / 176400;
  localparam int unsigned P_192K = CLK_HZ / 192000;
  localparam int unsigned P_MAX  = P_32K + P_32K / 8;
  localparam int unsigned P_MIN  = P_192K - P_192K / 16;

  typedef enum logic [3:0] {
    RATE_NONE, RATE_32K, RATE_44K, RATE_48K, RATE_64K, RATE_88K,
    RATE_96K, RATE_128K, RATE_176K, RATE_192K
  } acs_rate_t;

  typedef enum logic [1:0] {IN_NO_LOCK, IN_LOCK, IN_SYNC} acs_in_t;
  typedef enum logic [1:0] {BAND_SINGLE, BAND_DOUBLE, BAND_QUAD} acs_band_t;

  typedef struct packed {
    acs_band_t band;
    acs_rate_t rate;
    logic      cur_fmt;
    logic      cur_ext;
    acs_in_t   in_st;
  } acs_status_t;

  function automatic logic [PER_W-1:0] rate_period(input acs_rate_t r);
    unique case (r)
      RATE_32K:  rate_period = PER_W'(P_32K);
      RATE_44K:  rate_period = PER_W'(P_44K);
      RATE_64K:  rate_period = PER_W'(P_64K);
      RATE_88K:  rate_period = PER_W'(P_88K);
      RATE_96K:  rate_period = PER_W'(P_96K);
      RATE_128K: rate_period = PER_W'(P_128K);
      RATE_176K: rate_period = PER_W'(P_176K);
      RATE_192K: rate_period = PER_W'(P_192K);
      default:   rate_period = PER_W'(P_48K);
    endcase
  endfunction : rate_period

  function automatic acs_rate_t classify(input logic [PER_W-1:0] p);
    if (p > PER_W'(P_MAX) || p < PER_W'(P_MIN)) classify = RATE_NONE;
    else if (p > PER_W'((P_32K + P_44K) / 2))   classify = RATE_32K;
    else if (p > PER_W'((P_44K + P_48K) / 2))   classify = RATE_44K;
    else if (p > PER_W'((P_48K + P_64K) / 2))   classify = RATE_48K;
    else if (p > PER_W'((P_64K + P_88K) / 2))   classify = RATE_64K;
    else if (p > PER_W'((P_88K + P_96K) / 2))   classify = RATE_88K;
    else if (p > PER_W'((P_96K + P_128K) / 2))  classify = RATE_96K;
    else if (p > PER_W'((P_128K + P_176K) / 2)) classify = RATE_128K;
    else if (p > PER_W'((P_176K + P_192K) / 2)) classify = RATE_176K;
    else                                        classify = RATE_192K;
  endfunction : classify

  function automatic acs_band_t rate_band(input acs_rate_t r);
    if (r == RATE_176K || r == RATE_192K)   rate_band = BAND_QUAD;
    else if (r == RATE_88K || r == RATE_96K) rate_band = BAND_DOUBLE;
    else                                    rate_band = BAND_SINGLE;
  endfunction : rate_band

endpackage : acs_pkg

// ==== acs_sync2.sv ====
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level.
module acs_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : acs_sync2

// ==== acs_rate_meter.sv ====
// Measures the input frame period in pclk cycles and classifies it.
// Assumes frame_rise is a one-cycle pulse on pclk.
module acs_rate_meter
  import acs_pkg::*;
#(
  parameter int unsigned FRAME_TO = FRAME_TO_CYC
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Frame edges
  input  wire logic             frame_rise,
  // Result
  output logic [PER_W-1:0]      period_q,
  output logic                  valid_q,
  output acs_rate_t             rate_q
);
  logic [PER_W-1:0] cnt_q;
  logic             seen_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= '0;
      seen_q   <= 1'b0;
      period_q <= '0;
      valid_q  <= 1'b0;
      rate_q   <= RATE_NONE;
    end else if (frame_rise) begin
      cnt_q    <= PER_W'(1);
      seen_q   <= 1'b1;
      period_q <= cnt_q;
      valid_q  <= seen_q && (classify(cnt_q) != RATE_NONE);
      rate_q   <= seen_q ? classify(cnt_q) : RATE_NONE;
    end else if (cnt_q >= PER_W'(FRAME_TO)) begin
      seen_q  <= 1'b0;
      valid_q <= 1'b0;
      rate_q  <= RATE_NONE;
    end else begin
      cnt_q <= cnt_q + PER_W'(1);
    end
  end
endmodule : acs_rate_meter

// ==== acs_clock_source.sv ====
// Audio sample clock source selection, input lock/sync monitor and channel multiplexing.
// Assumes an APB master on pclk and an optical receiver whose pins are asynchronous.
// Notes on behaviour
// - Clock source selectable: internal oscillator as master or optical input as slave.
// - Input selected without lock: run from internal clock as master until lock.
// - Report clock actually used and its input format, apart from configured source.
// - Input status is one of no lock, locked, or locked and synchronous.
// - Measure input sample frequency, report nearest standard rate.
// - With input selected, keep checking and switch to recovered clock once valid.
// - At 88.2 or 96 kHz use two-way multiplexing, four channels.
// - At 176.4 or 192 kHz use four-way multiplexing, two channels.
// - Internal generator supports 32 up to 192 kHz including 64 and 128.
// - Three speed bands; all channel groups stay, unusable ones disabled.
// - Optical output switchable eight-channel or stereo consumer; input format auto detected.
// - Stereo output format carries only two channels on the transmitter.
//
// Decided for this implementation: the register offsets and the APB slave port.
module acs_clock_source
  import acs_pkg::*;
#(
  parameter int unsigned FRAME_TO = FRAME_TO_CYC
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Optical receiver pins
  input  wire logic        opt_link_clk,
  input  wire logic        opt_frame,
  input  wire logic        opt_rx_lock,
  input  wire logic        opt_fmt_spdif,
  // Clock and channel outputs
  output logic             fs_tick,
  output logic             cur_ext,
  output logic             cur_fmt_spdif,
  output logic [1:0]       smux_mode,
  output logic [7:0]       rx_chan_en,
  output logic [7:0]       tx_chan_en,
  output logic             tx_fmt_spdif,
  output logic             tx_consumer,
  // Interrupt
  output logic             irq
);

  typedef enum logic {ST_INT, ST_EXT} acs_state_t;

  logic [3:0]       pin_s;
  logic             link_s_d1_q;
  logic             frame_s_d1_q;
  logic             link_edge;
  logic             frame_rise;
  logic [7:0]       link_cnt_q;
  logic             link_act_q;
  logic [PER_W-1:0] meas_period;
  logic             meas_valid;
  acs_rate_t        meas_rate;
  logic             locked;
  logic             rate_match;
  acs_in_t          in_st_q;
  acs_state_t       state_q;
  logic             fmt_q;
  logic [31:0]      ctrl_q;
  logic             src_opt;
  acs_rate_t        cfg_rate;
  logic             out_spdif;
  logic [PER_W-1:0] div_cnt_q;
  logic             int_tick_q;
  acs_rate_t        run_rate;
  acs_band_t        band;
  acs_status_t      status;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic             in_lock_prev_q;
  logic             in_sync_prev_q;
  logic             cur_ext_prev_q;
  acs_rate_t        rate_prev_q;
  logic             setup;
  logic             access;
  logic             mapped;

  // Pin synchronisers
  acs_sync2 #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i ({opt_fmt_spdif, opt_rx_lock, opt_frame, opt_link_clk}),
    .sync_o  (pin_s)
  );

  // Edge detection on synchronised link clock and frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_s_d1_q  <= 1'b0;
      frame_s_d1_q <= 1'b0;
    end else begin
      link_s_d1_q  <= pin_s[0];
      frame_s_d1_q <= pin_s[1];
    end
  end
  assign link_edge  = pin_s[0] & ~link_s_d1_q;
  assign frame_rise = pin_s[1] & ~frame_s_d1_q;

  // Link clock activity watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_cnt_q <= '0;
      link_act_q <= 1'b0;
    end else if (link_edge) begin
      link_cnt_q <= '0;
      link_act_q <= 1'b1;
    end else if (link_cnt_q >= 8'(LINK_TO_CYC)) begin
      link_act_q <= 1'b0;
    end else begin
      link_cnt_q <= link_cnt_q + 8'd1;
    end
  end

  // Input frame rate measurement
  acs_rate_meter #(.FRAME_TO(FRAME_TO)) u_meter (
    .pclk       (pclk),
    .presetn    (presetn),
    .frame_rise (frame_rise),
    .period_q   (meas_period),
    .valid_q    (meas_valid),
    .rate_q     (meas_rate)
  );

  assign locked = pin_s[2] && link_act_q && meas_valid;

  // Sync compares input period against the running clock period
  always_comb begin
    rate_match = 1'b0;
    if (meas_period >= rate_period(run_rate))
      rate_match = (meas_period - rate_period(run_rate)) <= PER_W'(SYNC_TOL);
    else
      rate_match = (rate_period(run_rate) - meas_period) <= PER_W'(SYNC_TOL);
  end

  // Three-state input status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_st_q <= IN_NO_LOCK;
    end else if (!locked) begin
      in_st_q <= IN_NO_LOCK;
    end else if (rate_match) begin
      in_st_q <= IN_SYNC;
    end else begin
      in_st_q <= IN_LOCK;
    end
  end

  // Current clock reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_INT;
    end else begin
      unique case (state_q)
        ST_INT: if (src_opt && locked) state_q <= ST_EXT;
        ST_EXT: if (!src_opt || !locked) state_q <= ST_INT;
      endcase
    end
  end
  assign cur_ext = (state_q == ST_EXT);

  // Input format follows the receiver automatically
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_q <= 1'b0;
    end else if (locked) begin
      fmt_q <= pin_s[3];
    end
  end
  assign cur_fmt_spdif = fmt_q;

  // Control fields
  assign src_opt   = ctrl_q[CTRL_SRC_BIT];
  assign cfg_rate  = acs_rate_t'(ctrl_q[CTRL_RATE_LSB +: 4]);
  assign out_spdif = ctrl_q[CTRL_FMT_BIT];

  // Internal sample clock divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q  <= '0;
      int_tick_q <= 1'b0;
    end else if (div_cnt_q >= rate_period(cfg_rate) - PER_W'(1)) begin
      div_cnt_q  <= '0;
      int_tick_q <= 1'b1;
    end else begin
      div_cnt_q  <= div_cnt_q + PER_W'(1);
      int_tick_q <= 1'b0;
    end
  end

  // Running sample clock: recovered frame when slaved, else internal
  assign fs_tick  = cur_ext ? frame_rise : int_tick_q;
  assign run_rate = cur_ext ? meas_rate : cfg_rate;
  assign band     = rate_band(run_rate);

  // Speed band and channel masks
  always_comb begin
    smux_mode  = band;
    rx_chan_en = CH_ALL;
    unique case (band)
      BAND_DOUBLE: rx_chan_en = CH_SMUX;
      BAND_QUAD:   rx_chan_en = CH_QUAD;
      default:     rx_chan_en = CH_ALL;
    endcase
    tx_chan_en = out_spdif ? CH_QUAD : rx_chan_en;
  end
  assign tx_fmt_spdif = out_spdif;
  assign tx_consumer  = 1'b1;

  // Event detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_lock_prev_q <= 1'b0;
      in_sync_prev_q <= 1'b0;
      cur_ext_prev_q <= 1'b0;
      rate_prev_q    <= RATE_NONE;
    end else begin
      in_lock_prev_q <= (in_st_q != IN_NO_LOCK);
      in_sync_prev_q <= (in_st_q == IN_SYNC);
      cur_ext_prev_q <= cur_ext;
      rate_prev_q    <= meas_rate;
    end
  end
  always_comb begin
    irq_set                = '0;
    irq_set[IRQ_LOCK_UP]   = (in_st_q != IN_NO_LOCK) && !in_lock_prev_q;
    irq_set[IRQ_LOCK_DOWN] = (in_st_q == IN_NO_LOCK) && in_lock_prev_q;
    irq_set[IRQ_SYNC_CHG]  = (in_st_q == IN_SYNC) != in_sync_prev_q;
    irq_set[IRQ_SRC_CHG]   = cur_ext != cur_ext_prev_q;
    irq_set[IRQ_RATE_CHG]  = meas_rate != rate_prev_q;
  end

  // APB decode
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign pready  = 1'b1;
  assign mapped  = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) || (paddr == OFF_IRQ_STAT)
                || (paddr == OFF_IRQ_CLR) || (paddr == OFF_IRQ_EN);
  assign pslverr = access && !mapped;
  assign irq_clr = (access && pwrite && paddr == OFF_IRQ_CLR && pstrb[0]) ?
                   pwdata[IRQ_W-1:0] : '0;

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else if (access && pwrite && paddr == OFF_CTRL) begin
      if (pstrb[0]) ctrl_q[7:0]  <= pwdata[7:0] & 8'hF1;
      if (pstrb[1]) ctrl_q[15:8] <= pwdata[15:8] & 8'h01;
    end
  end

  // Interrupt status, enable and output; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq_en_q   <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      if (access && pwrite && paddr == OFF_IRQ_EN && pstrb[0])
        irq_en_q <= pwdata[IRQ_W-1:0];
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // Status word
  always_comb begin
    status.band    = band;
    status.rate    = meas_rate;
    status.cur_fmt = fmt_q;
    status.cur_ext = cur_ext;
    status.in_st   = in_st_q;
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      unique case (paddr)
        OFF_CTRL:     prdata <= ctrl_q;
        OFF_STATUS:   prdata <= {22'h00_0000, status};
        OFF_IRQ_STAT: prdata <= {27'h000_0000, irq_stat_q};
        OFF_IRQ_EN:   prdata <= {27'h000_0000, irq_en_q};
        default:      prdata <= '0;
      endcase
    end
  end

  // Checks
  sequence s_lost_lock;
    cur_ext && !locked;
  endsequence
  sequence s_gain_lock;
    src_opt && locked && !cur_ext;
  endsequence

  AST_SRC_INT: assert property (@(posedge pclk) disable iff (!presetn)
    !src_opt |=> !cur_ext) else $error("external clock used while internal selected");
  AST_FALLBACK: assert property (@(posedge pclk) disable iff (!presetn)
    s_lost_lock |=> !cur_ext && fs_tick == int_tick_q) else $error("no fallback on lost lock");
  AST_CUR_READ: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == OFF_STATUS |=> prdata[2] == $past(cur_ext))
    else $error("status read shows wrong clock reference");
  AST_NOLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    !locked |=> in_st_q == IN_NO_LOCK) else $error("status not no-lock");
  AST_RATE_NONE: assert property (@(posedge pclk) disable iff (!presetn)
    !meas_valid |-> !locked ##1 in_st_q == IN_NO_LOCK)
    else $error("lock without valid rate");
  AST_SWITCH: assert property (@(posedge pclk) disable iff (!presetn)
    s_gain_lock |=> cur_ext) else $error("no switch to recovered clock");
  AST_SMUX2: assert property (@(posedge pclk) disable iff (!presetn)
    (run_rate == RATE_96K || run_rate == RATE_88K) |-> rx_chan_en == CH_SMUX && smux_mode == 2'd1)
    else $error("double speed mask wrong");
  AST_SMUX4: assert property (@(posedge pclk) disable iff (!presetn)
    (run_rate == RATE_192K || run_rate == RATE_176K) |-> rx_chan_en == CH_QUAD && smux_mode == 2'd2)
    else $error("quad speed mask wrong");
  AST_INT_GAP: assert property (@(posedge pclk) disable iff (!presetn)
    int_tick_q && $stable(ctrl_q) |=> !int_tick_q [*8]) else $error("internal tick too close");
  AST_SPDIF_TX: assert property (@(posedge pclk) disable iff (!presetn)
    out_spdif |-> tx_chan_en == CH_QUAD && tx_consumer) else $error("stereo tx mask wrong");
  AST_SYNC_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
    in_st_q == IN_SYNC |-> $past(locked) && $past(rate_match)) else $error("sync without match");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    |(irq_stat_q & irq_en_q) |=> irq) else $error("irq not raised");
  AST_SINGLE: assert property (@(posedge pclk) disable iff (!presetn)
    band == BAND_SINGLE |-> rx_chan_en == CH_ALL && smux_mode == 2'd0)
    else $error("single speed mask wrong");
  AST_LOCK_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
    in_st_q != IN_NO_LOCK ##1 in_st_q == IN_NO_LOCK |=> irq_stat_q[IRQ_LOCK_DOWN])
    else $error("lock loss event not recorded");

endmodule : acs_clock_source

// ==== acs_opt_model.sv ====
// Behavioural model of the optical source feeding the receiver pins.
// Assumes the bench gives the frame period in pclk cycles of 10 ns.
module acs_opt_model (
  // Control from the bench
  input  wire logic        en,
  input  wire logic [15:0] per,
  input  wire logic        fmt,
  // Receiver pins
  output logic             link_clk,
  output logic             frame,
  output logic             lock,
  output logic             fmt_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial link_clk = 1'b0;
  initial frame = 1'b0;
  assign lock = en;
  assign fmt_o = fmt;

  // Link clock runs only while frames are sent
  always begin
    wait (en);
    #62.5 link_clk = ~link_clk;
  end

  // One frame rise each period
  always begin
    wait (en);
    frame = 1'b1;
    #(per * 5.0);
    frame = 1'b0;
    #(per * 5.0);
  end
endmodule : acs_opt_model

// ==== acs_clock_source_tb_top.sv ====
// Testbench for the clock source block: APB tasks and directed tests.
// Assumes the optical model drives the receiver pins.
module acs_clock_source_tb_top import acs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned FTO = 4000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ex;
  logic [3:0]  pstrb;
  logic        lclk, frm, lck, fmt_in, fs_tick, cur_ext, cur_fmt, tx_fmt, tx_cons, irq;
  logic [1:0]  smux, bnd;
  logic [7:0]  rx_en, tx_en, msk;
  logic        m_en, m_fmt, er;
  logic [15:0] m_per;
  int          miscompares, total_checks, cyc, nt;
  int unsigned per_tab [10] = '{0, P_32K, P_44K, P_48K, P_64K, P_88K, P_96K, P_128K,
                                P_176K, P_192K};

  acs_clock_source #(.FRAME_TO(FTO)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opt_link_clk(lclk), .opt_frame(frm), .opt_rx_lock(lck),
    .opt_fmt_spdif(fmt_in), .fs_tick(fs_tick), .cur_ext(cur_ext),
    .cur_fmt_spdif(cur_fmt), .smux_mode(smux), .rx_chan_en(rx_en), .tx_chan_en(tx_en),
    .tx_fmt_spdif(tx_fmt), .tx_consumer(tx_cons), .irq(irq));

  acs_opt_model peer (.en(m_en), .per(m_per), .fmt(m_fmt), .link_clk(lclk),
    .frame(frm), .lock(lck), .fmt_o(fmt_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      miscompares++;
      finish_test;
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; read data and error land in rd and er
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cyc

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    m_en = 1'b0;
    m_fmt = 1'b1;
    m_per = 16'(P_48K);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_CTRL, 0);
    chk(rd, CTRL_RST);
    apb(0, OFF_STATUS, 0);
    chk(rd, 32'h0000_0000);
    chk({tx_cons, rx_en, tx_en, smux}, {1'b1, CH_ALL, CH_ALL, 2'd0});
    apb(0, 12'h020, 0);
    chk({er, rd}, {1'b1, 32'h0000_0000});
    apb(1, OFF_CTRL, 32'hFFFF_FFFF);
    apb(0, OFF_CTRL, 0);
    chk(rd, 32'h0000_01F1);
    apb(1, OFF_IRQ_EN, 32'h0000_001F);
    apb(1, OFF_CTRL, 32'h0000_0031);
    wait_cyc(200);
    chk(cur_ext, 1'b0);
    // Input appears while the optical source is selected
    m_en <= 1'b1;
    wait_cyc(3 * P_48K + 100);
    apb(0, OFF_STATUS, 0);
    chk(rd, 32'h0000_003E);
    chk({cur_ext, cur_fmt, irq}, 3'b111);
    apb(0, OFF_IRQ_STAT, 0);
    chk(rd, 32'h0000_001D);
    apb(1, OFF_IRQ_CLR, 32'h0000_001F);
    apb(0, OFF_IRQ_STAT, 0);
    chk({irq, rd}, 33'h0);
    apb(0, OFF_IRQ_CLR, 0);
    chk(rd, 32'h0000_0000);
    // Input lost: fall back to internal, masked then unmasked event
    apb(1, OFF_IRQ_EN, 32'h0000_0000);
    m_en <= 1'b0;
    wait_cyc(100);
    apb(0, OFF_STATUS, 0);
    chk({cur_ext, irq, rd[2:0]}, 5'b0);
    apb(0, OFF_IRQ_STAT, 0);
    chk(rd & 32'h2, 32'h2);
    apb(1, OFF_IRQ_EN, 32'h0000_0002);
    wait_cyc(2);
    chk(irq, 1'b1);
    wait_cyc(FTO + 100);
    apb(0, OFF_STATUS, 0);
    chk(rd & 32'hF0, 32'h0);
    apb(1, OFF_IRQ_CLR, 32'h0000_001F);
    // Every rate on the internal clock with a matching input
    for (int i = 1; i < 10; i++) begin
      m_per <= 16'(per_tab[i]);
      m_en  <= 1'b1;
      apb(1, OFF_CTRL, 32'(i) << 4);
      wait_cyc(3 * per_tab[i] + 100);
      bnd = (i >= 8) ? 2'd2 : (i == 5 || i == 6) ? 2'd1 : 2'd0;
      msk = (bnd == 2'd2) ? CH_QUAD : (bnd == 2'd1) ? CH_SMUX : CH_ALL;
      ex = (32'(bnd) << 8) | (32'(i) << 4) | 32'h2;
      apb(0, OFF_STATUS, 0);
      chk(rd & 32'h3F7, ex);
      chk({smux, rx_en, tx_en}, {bnd, msk, msk});
    end
    // Configured rate differs from the input
    apb(1, OFF_CTRL, 32'h0000_0080);
    m_fmt <= 1'b0;
    wait_cyc(3 * P_192K);
    apb(0, OFF_STATUS, 0);
    chk(rd & 32'hB, 32'h1);
    // Internal ticks at the configured rate
    do @(posedge pclk); while (fs_tick !== 1'b1);
    nt = 0;
    repeat (2 * P_176K + P_176K / 2) begin
      @(posedge pclk);
      if (fs_tick === 1'b1) nt++;
    end
    chk(nt, 2);
    apb(1, OFF_CTRL, 32'h0000_0130);
    wait_cyc(1);
    chk({tx_fmt, rx_en, tx_en}, {1'b1, CH_ALL, 8'h03});
    finish_test;
  end
endmodule : acs_clock_source_tb_top
